/* inc/uic_pkg.sv */
`default_nettype none
package uic_pkg;
	// register byte offsets
	localparam logic [4:0] OFS_TX_DATA = 5'h00;
	localparam logic [4:0] OFS_RX_DATA = 5'h04;
	localparam logic [4:0] OFS_BAUD = 5'h08;
	localparam logic [4:0] OFS_MODE = 5'h0C;
	localparam logic [4:0] OFS_CTRL = 5'h10;
	localparam logic [4:0] OFS_SPECIAL = 5'h14;
	// mode_register fields
	localparam int MODE_CLKDIR = 0;
	localparam int MODE_POL = 1;
	localparam int MODE_SRC = 2;
	localparam int MODE_OD = 4;
	localparam int MODE_ODDEVEN = 5;
	localparam int MODE_PARITY = 6;
	localparam int MODE_HSFUNC = 7;
	localparam int MODE_HSDIS = 8;
	// control and status fields
	localparam int CTRL_TE = 0;
	localparam int CTRL_RXON = 1;
	localparam int CTRL_IRQSEL = 2;
	localparam int CTRL_TXBE = 4;
	localparam int CTRL_TXEMPTY = 5;
	localparam int CTRL_RXDONE = 6;
	// special_mode_register fields
	localparam int SPC_SAMPLE = 0;
	localparam int SPC_ACLR = 1;
	localparam int SPC_START = 2;
	localparam int SPC_COLLEN = 3;
	localparam int SPC_COLLFLAG = 4;
	// reset values
	localparam logic [7:0] BAUD_RST = 8'h00;
	localparam logic [1:0] SRC_RST = 2'h0;
	localparam logic [8:0] DATA_RST = 9'h000;
	// frame timing: start, nine data, stop; 16 oversample ticks per bit
	localparam logic [3:0] FRAME_LAST = 4'hA;
	localparam logic [3:0] DATA_LAST = 4'h8;
	localparam logic [3:0] OS_MID = 4'h7;
	// prescaler masks for the four count sources
	localparam logic [5:0] PRESC_F1 = 6'h00;
	localparam logic [5:0] PRESC_F8 = 6'h07;
	localparam logic [5:0] PRESC_F32 = 6'h1F;
	localparam logic [5:0] PRESC_F64 = 6'h3F;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_WAIT = 2'b01,
		TX_SEND = 2'b10
	} uic_tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} uic_rx_state_t;

	// one-shot timer that paces collision sampling per channel
	function automatic int sample_timer(input int ch);
		case (ch)
			0: sample_timer = 3;
			1: sample_timer = 4;
			2: sample_timer = 0;
			3: sample_timer = 4;
			4: sample_timer = 3;
			default: sample_timer = 0;
		endcase
	endfunction : sample_timer

	// prescaler mask for a count source select code
	function automatic logic [5:0] presc_mask(input logic [1:0] sel);
		case (sel)
			2'h0: presc_mask = PRESC_F1;
			2'h1: presc_mask = PRESC_F8;
			2'h2: presc_mask = PRESC_F32;
			default: presc_mask = PRESC_F64;
		endcase
	endfunction : presc_mask
endpackage : uic_pkg
`default_nettype wire

/* inc/uic_clk_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface uic_clk_if;
	logic [1:0] src_sel;
	logic ext_sel;
	logic ext_clk;
	logic [7:0] div;
	logic restart;
	logic over_tick;
	logic bit_tick;
	modport gen (input src_sel, ext_sel, ext_clk, div, restart, output over_tick, bit_tick);
	modport core (output src_sel, ext_sel, ext_clk, div, restart, input over_tick, bit_tick);
endinterface : uic_clk_if
`default_nettype wire

/* hdl/uic_baud_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module uic_baud_gen (
	input wire logic i_clk,
	input wire logic i_rstn,
	uic_clk_if.gen clk_if
);
	logic [5:0] presc_reg;
	logic ext_prev_reg;
	logic [7:0] brg_reg;
	logic [3:0] os_reg;
	logic src_tick;
	logic brg_tick;

	// count source: prescaled system clock or external clock rising edge
	assign src_tick = clk_if.ext_sel ? (clk_if.ext_clk & ~ext_prev_reg)
		: ((presc_reg & uic_pkg::presc_mask(clk_if.src_sel)) == 6'h00);
	assign brg_tick = src_tick && (brg_reg == 8'h00);
	assign clk_if.over_tick = brg_tick;
	assign clk_if.bit_tick = brg_tick && (os_reg == 4'hF);

	// free running prescaler and edge history
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			presc_reg <= 6'h00;
			ext_prev_reg <= 1'b0;
		end else begin
			presc_reg <= presc_reg + 6'h01;
			ext_prev_reg <= clk_if.ext_clk;
		end
	end

	// 8-bit divider, n+1 source ticks per oversample tick
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			brg_reg <= uic_pkg::BAUD_RST;
		end else if (src_tick) begin
			brg_reg <= (brg_reg == 8'h00) ? clk_if.div : brg_reg - 8'h01;
		end
	end

	// sixteen oversample ticks per bit, realigned when a frame starts on an input rise
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			os_reg <= 4'h0;
		end else if (clk_if.restart) begin
			os_reg <= 4'h0;
		end else if (brg_tick) begin
			os_reg <= os_reg + 4'h1;
		end
	end
endmodule : uic_baud_gen
`default_nettype wire

/* hdl/uic_channel.sv */
`timescale 1ns/10ps
`default_nettype none
module uic_channel #(
	parameter int CHANNEL = 0
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_serial_in_pin,
	output logic o_serial_out_pin,
	output logic o_serial_out_oe,
	input wire logic i_ext_clk,
	input wire logic [4:0] i_timer_underflow,
	output logic o_tx_irq,
	output logic o_rx_irq,
	output logic o_collision_irq
);
	localparam int TIMER_IDX = uic_pkg::sample_timer(CHANNEL);
	localparam logic FORCE_OD = (CHANNEL == 2);

	uic_clk_if clk_if ();

	logic ack_reg;
	logic wr_go;
	logic rd_go;
	logic [31:0] rd_next;
	logic [8:0] tx_buf_reg;
	logic tx_full_reg;
	logic [8:0] rx_buf_reg;
	logic rx_done_reg;
	logic [7:0] baud_reg;
	logic clkdir_reg;
	logic pol_reg;
	logic [1:0] src_reg;
	logic od_reg;
	logic odd_even_reg;
	logic hs_func_reg;
	logic te_reg;
	logic rx_on_reg;
	logic irq_sel_reg;
	logic sample_sel_reg;
	logic aclr_reg;
	logic start_sel_reg;
	logic coll_en_reg;
	logic coll_flag_reg;
	uic_pkg::uic_tx_state_t tx_state_reg;
	logic [10:0] tx_frame_reg;
	logic [3:0] tx_cnt_reg;
	logic tx_level_reg;
	logic buf_empty_ev;
	logic tx_done_ev;
	uic_pkg::uic_rx_state_t rx_state_reg;
	logic [3:0] rx_os_reg;
	logic [3:0] rx_cnt_reg;
	logic [8:0] rx_shift_reg;
	logic rx_prev_reg;
	logic rx_level;
	logic rx_rise;
	logic rx_fall;
	logic rx_mid;
	logic rx_done_ev;
	logic sample_ev;
	logic open_drain;

	uic_baud_gen u_baud (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.clk_if(clk_if.gen)
	);

	// baud generator configuration
	assign clk_if.src_sel = src_reg;
	assign clk_if.ext_sel = clkdir_reg;
	assign clk_if.ext_clk = i_ext_clk;
	assign clk_if.div = baud_reg;
	assign clk_if.restart = (tx_state_reg == uic_pkg::TX_WAIT) && start_sel_reg && rx_rise;

	// bus slave: one wait cycle, then the access completes
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
	assign wr_go = i_avs_write & ack_reg;
	assign rd_go = i_avs_read & ack_reg;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
		end
	end

	// read data mux; unmapped offsets read zero
	always_comb begin
		rd_next = 32'h0000_0000;
		case (i_avs_address)
			uic_pkg::OFS_TX_DATA: rd_next[8:0] = tx_buf_reg;
			uic_pkg::OFS_RX_DATA: rd_next[8:0] = rx_buf_reg;
			uic_pkg::OFS_BAUD: rd_next[7:0] = baud_reg;
			uic_pkg::OFS_MODE: begin
				rd_next[uic_pkg::MODE_CLKDIR] = clkdir_reg;
				rd_next[uic_pkg::MODE_POL] = pol_reg;
				rd_next[uic_pkg::MODE_SRC +: 2] = src_reg;
				rd_next[uic_pkg::MODE_OD] = od_reg & ~FORCE_OD;
				rd_next[uic_pkg::MODE_ODDEVEN] = odd_even_reg;
				rd_next[uic_pkg::MODE_PARITY] = 1'b0;
				rd_next[uic_pkg::MODE_HSFUNC] = hs_func_reg;
				rd_next[uic_pkg::MODE_HSDIS] = 1'b1;
			end
			uic_pkg::OFS_CTRL: begin
				rd_next[uic_pkg::CTRL_TE] = te_reg;
				rd_next[uic_pkg::CTRL_RXON] = rx_on_reg;
				rd_next[uic_pkg::CTRL_IRQSEL] = irq_sel_reg;
				rd_next[uic_pkg::CTRL_TXBE] = ~tx_full_reg;
				rd_next[uic_pkg::CTRL_TXEMPTY] = (tx_state_reg == uic_pkg::TX_IDLE);
				rd_next[uic_pkg::CTRL_RXDONE] = rx_done_reg;
			end
			uic_pkg::OFS_SPECIAL: begin
				rd_next[uic_pkg::SPC_SAMPLE] = sample_sel_reg;
				rd_next[uic_pkg::SPC_ACLR] = aclr_reg;
				rd_next[uic_pkg::SPC_START] = start_sel_reg;
				rd_next[uic_pkg::SPC_COLLEN] = coll_en_reg;
				rd_next[uic_pkg::SPC_COLLFLAG] = coll_flag_reg;
			end
			default: rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_avs_readdata <= 32'h0000_0000;
		end else if (i_avs_read && !ack_reg) begin
			o_avs_readdata <= rd_next;
		end
	end

	// configuration registers; parity and handshake have no effect here
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			baud_reg <= uic_pkg::BAUD_RST;
			clkdir_reg <= 1'b0;
			pol_reg <= 1'b0;
			src_reg <= uic_pkg::SRC_RST;
			od_reg <= 1'b0;
			odd_even_reg <= 1'b0;
			hs_func_reg <= 1'b0;
			rx_on_reg <= 1'b0;
			irq_sel_reg <= 1'b0;
			sample_sel_reg <= 1'b0;
			aclr_reg <= 1'b0;
			start_sel_reg <= 1'b0;
			coll_en_reg <= 1'b0;
		end else if (wr_go) begin
			case (i_avs_address)
				uic_pkg::OFS_BAUD: baud_reg <= i_avs_writedata[7:0];
				uic_pkg::OFS_MODE: begin
					clkdir_reg <= i_avs_writedata[uic_pkg::MODE_CLKDIR];
					pol_reg <= i_avs_writedata[uic_pkg::MODE_POL];
					src_reg <= i_avs_writedata[uic_pkg::MODE_SRC +: 2];
					od_reg <= i_avs_writedata[uic_pkg::MODE_OD];
					odd_even_reg <= i_avs_writedata[uic_pkg::MODE_ODDEVEN];
					hs_func_reg <= i_avs_writedata[uic_pkg::MODE_HSFUNC];
				end
				uic_pkg::OFS_CTRL: begin
					rx_on_reg <= i_avs_writedata[uic_pkg::CTRL_RXON];
					irq_sel_reg <= i_avs_writedata[uic_pkg::CTRL_IRQSEL];
				end
				uic_pkg::OFS_SPECIAL: begin
					sample_sel_reg <= i_avs_writedata[uic_pkg::SPC_SAMPLE];
					aclr_reg <= i_avs_writedata[uic_pkg::SPC_ACLR];
					start_sel_reg <= i_avs_writedata[uic_pkg::SPC_START];
					coll_en_reg <= i_avs_writedata[uic_pkg::SPC_COLLEN];
				end
				default: ;
			endcase
		end
	end

	// transmit enable; auto-clear overrides a software write
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			te_reg <= 1'b0;
		end else if (aclr_reg && coll_flag_reg) begin
			te_reg <= 1'b0;
		end else if (wr_go && i_avs_address == uic_pkg::OFS_CTRL) begin
			te_reg <= i_avs_writedata[uic_pkg::CTRL_TE];
		end
	end

	// transmit buffer; a write in the hand-over cycle refills the buffer
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_buf_reg <= uic_pkg::DATA_RST;
			tx_full_reg <= 1'b0;
		end else if (wr_go && i_avs_address == uic_pkg::OFS_TX_DATA) begin
			tx_buf_reg <= i_avs_writedata[8:0];
			tx_full_reg <= 1'b1;
		end else if (buf_empty_ev) begin
			tx_full_reg <= 1'b0;
		end
	end

	// receive pin level after polarity, and its edges
	assign rx_level = i_serial_in_pin ^ pol_reg;
	assign rx_rise = rx_level & ~rx_prev_reg;
	assign rx_fall = ~rx_level & rx_prev_reg;
	assign buf_empty_ev = (tx_state_reg == uic_pkg::TX_IDLE) && te_reg && tx_full_reg;
	assign tx_done_ev = (tx_state_reg == uic_pkg::TX_SEND) && clk_if.bit_tick
		&& (tx_cnt_reg == uic_pkg::FRAME_LAST);

	// transmitter: each character is one start, nine data and one stop bit on the line
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_state_reg <= uic_pkg::TX_IDLE;
			tx_frame_reg <= 11'h7FF;
			tx_cnt_reg <= 4'h0;
			tx_level_reg <= 1'b1;
		end else if (!te_reg) begin
			tx_state_reg <= uic_pkg::TX_IDLE;
			tx_level_reg <= 1'b1;
		end else begin
			case (tx_state_reg)
				uic_pkg::TX_IDLE: begin
					if (buf_empty_ev) begin
						tx_frame_reg <= {1'b1, tx_buf_reg, 1'b0};
						tx_state_reg <= uic_pkg::TX_WAIT;
					end
				end
				uic_pkg::TX_WAIT: begin
					if (start_sel_reg ? rx_rise : clk_if.bit_tick) begin
						tx_state_reg <= uic_pkg::TX_SEND;
						tx_cnt_reg <= 4'h0;
						tx_level_reg <= tx_frame_reg[0];
					end
				end
				uic_pkg::TX_SEND: begin
					if (tx_done_ev) begin
						tx_state_reg <= uic_pkg::TX_IDLE;
						tx_level_reg <= 1'b1;
					end else if (clk_if.bit_tick) begin
						tx_cnt_reg <= tx_cnt_reg + 4'h1;
						tx_level_reg <= tx_frame_reg[tx_cnt_reg + 4'h1];
					end
				end
				default: tx_state_reg <= uic_pkg::TX_IDLE;
			endcase
		end
	end

	// pin drive: open drain only pulls low
	assign open_drain = od_reg | FORCE_OD;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_serial_out_pin <= ~FORCE_OD; // open drain never drives high
			o_serial_out_oe <= 1'b0;
		end else begin
			o_serial_out_pin <= open_drain ? 1'b0 : (tx_level_reg ^ pol_reg);
			o_serial_out_oe <= open_drain ? ~(tx_level_reg ^ pol_reg) : 1'b1;
		end
	end

	// receiver: mid-bit sampling on the oversample tick
	assign rx_mid = clk_if.over_tick && (rx_os_reg == uic_pkg::OS_MID);
	assign rx_done_ev = (rx_state_reg == uic_pkg::RX_STOP) && rx_mid;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_state_reg <= uic_pkg::RX_IDLE;
			rx_os_reg <= 4'h0;
			rx_cnt_reg <= 4'h0;
			rx_shift_reg <= uic_pkg::DATA_RST;
		end else if (!rx_on_reg) begin
			rx_state_reg <= uic_pkg::RX_IDLE;
		end else begin
			if (clk_if.over_tick) begin
				rx_os_reg <= rx_os_reg + 4'h1;
			end
			case (rx_state_reg)
				uic_pkg::RX_IDLE: begin
					if (rx_fall) begin
						rx_state_reg <= uic_pkg::RX_START;
						rx_os_reg <= 4'h0;
					end
				end
				uic_pkg::RX_START: begin
					if (rx_mid) begin
						rx_state_reg <= rx_level ? uic_pkg::RX_IDLE : uic_pkg::RX_DATA;
						rx_cnt_reg <= 4'h0;
					end
				end
				uic_pkg::RX_DATA: begin
					if (rx_mid) begin
						rx_shift_reg <= {rx_level, rx_shift_reg[8:1]};
						rx_cnt_reg <= rx_cnt_reg + 4'h1;
						if (rx_cnt_reg == uic_pkg::DATA_LAST) begin
							rx_state_reg <= uic_pkg::RX_STOP;
						end
					end
				end
				uic_pkg::RX_STOP: begin
					if (rx_mid) begin
						rx_state_reg <= uic_pkg::RX_IDLE;
					end
				end
				default: rx_state_reg <= uic_pkg::RX_IDLE;
			endcase
		end
	end

	// receive buffer and completion flag; a new character wins over the read
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_buf_reg <= uic_pkg::DATA_RST;
			rx_done_reg <= 1'b0;
		end else if (rx_done_ev) begin
			rx_buf_reg <= rx_shift_reg;
			rx_done_reg <= 1'b1;
		end else if (rd_go && i_avs_address == uic_pkg::OFS_RX_DATA) begin
			rx_done_reg <= 1'b0;
		end
	end

	// collision sampling event from bit clock or the channel's timer
	assign sample_ev = sample_sel_reg ? i_timer_underflow[TIMER_IDX]
		: clk_if.bit_tick;

	// sticky collision flag; write one to clear, a new mismatch wins
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			coll_flag_reg <= 1'b0;
		end else if (sample_ev && (tx_level_reg != rx_level)) begin
			coll_flag_reg <= 1'b1;
		end else if (wr_go && i_avs_address == uic_pkg::OFS_SPECIAL
			&& i_avs_writedata[uic_pkg::SPC_COLLFLAG]) begin
			coll_flag_reg <= 1'b0;
		end
	end

	// channels 0 and 1 gate the request with their enable bit
	assign o_collision_irq = coll_flag_reg & (coll_en_reg | (CHANNEL > 1));

	// interrupt pulses and edge history
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_tx_irq <= 1'b0;
			o_rx_irq <= 1'b0;
			rx_prev_reg <= 1'b1;
		end else begin
			o_tx_irq <= irq_sel_reg ? tx_done_ev : buf_empty_ev;
			o_rx_irq <= rx_done_ev;
			rx_prev_reg <= rx_level;
		end
	end

	AST_COLL_SET: assert property (@(posedge i_clk) disable iff (!i_rstn)
		sample_ev && (tx_level_reg != rx_level) |=> coll_flag_reg)
		else $error("mismatch did not set collision flag");
	AST_COLL_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
		coll_flag_reg && !wr_go |=> coll_flag_reg)
		else $error("collision flag dropped without a clear");
	AST_AUTO_CLR: assert property (@(posedge i_clk) disable iff (!i_rstn)
		aclr_reg && coll_flag_reg |=> !te_reg ##1 tx_state_reg == uic_pkg::TX_IDLE)
		else $error("auto-clear did not stop transmission");
	AST_TE_GATE: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!te_reg |=> tx_state_reg == uic_pkg::TX_IDLE && tx_level_reg)
		else $error("transmitter active while disabled");
	AST_START_RISE: assert property (@(posedge i_clk) disable iff (!i_rstn)
		tx_state_reg == uic_pkg::TX_WAIT && te_reg && start_sel_reg && rx_rise
		|=> tx_state_reg == uic_pkg::TX_SEND && !tx_level_reg)
		else $error("start on input rise missed");
	AST_FRAME_END: assert property (@(posedge i_clk) disable iff (!i_rstn)
		tx_done_ev && te_reg && !(aclr_reg && coll_flag_reg)
		|=> tx_level_reg ##1 o_serial_out_pin == (open_drain ? 1'b0 : ~$past(pol_reg)))
		else $error("frame did not end on stop level");
	AST_OPEN_DRAIN: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$past(open_drain) |-> !o_serial_out_pin)
		else $error("open drain output drove high");
	AST_RX_STORE: assert property (@(posedge i_clk) disable iff (!i_rstn)
		rx_done_ev |=> rx_done_reg && o_rx_irq && rx_buf_reg == $past(rx_shift_reg))
		else $error("received character not stored");
	AST_TX_IRQ: assert property (@(posedge i_clk) disable iff (!i_rstn)
		buf_empty_ev && !irq_sel_reg
		&& !(wr_go && i_avs_address == uic_pkg::OFS_TX_DATA) |=> o_tx_irq && !tx_full_reg)
		else $error("buffer empty request missing");
	AST_BUS_WAIT: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_avs_waitrequest && $stable(i_avs_address) |=> !o_avs_waitrequest)
		else $error("waitrequest held more than one cycle");
endmodule : uic_channel
`default_nettype wire

/* verif/uic_bus_node.sv */
`timescale 1ns/10ps
`default_nettype none
// another node on the shared line; the line has a pull-up
module uic_bus_node (
	input wire logic i_drv,
	input wire logic i_oe,
	input wire logic i_jam,
	output logic o_line
);
	// wired-and: a jamming node wins, a released line floats high
	assign o_line = i_jam ? 1'b0 : (i_oe ? i_drv : 1'b1);
endmodule : uic_bus_node
`default_nettype wire

/* verif/uart_bus_collision_mode_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module uart_bus_collision_mode_tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdat = 32'h00000000;
	logic [4:0] tmr = 5'h00;
	logic jam = 1'b0;
	logic ext = 1'b0;
	logic line;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest, o_serial_out_pin, o_serial_out_oe;
	logic o_tx_irq, o_rx_irq, o_collision_irq;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [8:0] dat;
	int failures = 0;
	int checks_done = 0;
	int tx_pulses = 0;
	int cyc = 0;
	int n;

	uic_channel #(.CHANNEL(0)) uic_channel_inst (
		.i_clk(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .i_serial_in_pin(line),
		.o_serial_out_pin(o_serial_out_pin), .o_serial_out_oe(o_serial_out_oe),
		.i_ext_clk(ext), .i_timer_underflow(tmr), .o_tx_irq(o_tx_irq),
		.o_rx_irq(o_rx_irq), .o_collision_irq(o_collision_irq)
	);

	uic_bus_node uic_bus_node_inst (
		.i_drv(o_serial_out_pin), .i_oe(o_serial_out_oe), .i_jam(jam), .o_line(line)
	);

	// 20 MHz clock
	always #25 clk = ~clk;

	// external count source, one rising edge every two clocks
	always @(posedge clk) ext <= ~ext;

	// compare and count
	task check_val(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
		end
	endtask : check_val

	task print_verdict;
		$display("checks %0d, mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict

	// hang guard, the whole run needs about 3000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			print_verdict();
		end
	end

	// read data taken at the edge where waitrequest is low; take the oldest note
	always @(posedge clk) begin
		if (rd && o_avs_waitrequest === 1'b0) begin
			check_val(o_avs_readdata & msk_q[0], exp_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
		if (o_tx_irq === 1'b1) tx_pulses++;
	end

	// one bus access, held until waitrequest is sampled low at a rising edge
	task bus_go(input logic [4:0] a, input logic r, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		rd <= r;
		wr <= !r;
		do @(posedge clk); while (o_avs_waitrequest !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus_go

	task bus_rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus_go(a, 1'b1, 32'h00000000);
	endtask : bus_rd

	// 0 receive irq, 1 collision irq, 2 line low
	task wait_for(input int which, input int lim);
		int k;
		k = 0;
		while ((which == 0 ? o_rx_irq : which == 1 ? o_collision_irq : !o_serial_out_pin)
			!== 1'b1 && k < lim) begin
			@(posedge clk);
			k++;
		end
		check_val(k < lim, 1);
	endtask : wait_for

	task pulse_timer(input logic [4:0] v);
		@(posedge clk);
		tmr <= v;
		@(posedge clk);
		tmr <= 5'h00;
		repeat (4) @(posedge clk);
	endtask : pulse_timer

	initial begin
		void'($urandom(67927));
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		// mode register: parity off, handshake disabled, odd/even kept
		bus_rd(uic_pkg::OFS_MODE, 32'h00000100, 32'h00000140);
		bus_go(uic_pkg::OFS_MODE, 1'b0, 32'h000000E0);
		bus_rd(uic_pkg::OFS_MODE, 32'h000001A0, 32'h000001E0);
		bus_rd(5'h18, 32'h00000000, 32'hFFFFFFFF);
		// count source /8, divider 0: 128 clocks a bit
		bus_go(uic_pkg::OFS_MODE, 1'b0, 32'h00000004);
		bus_go(uic_pkg::OFS_SPECIAL, 1'b0, 32'h0000000A);
		bus_go(uic_pkg::OFS_CTRL, 1'b0, 32'h00000003);
		dat = 9'($urandom()) | 9'h001;
		bus_go(uic_pkg::OFS_TX_DATA, 1'b0, {23'h000000, dat});
		wait_for(2, 400);
		n = 0;
		while (o_serial_out_pin === 1'b0) begin
			n++;
			@(posedge clk);
		end
		check_val(n, 128);
		wait_for(0, 2000);
		bus_rd(uic_pkg::OFS_RX_DATA, {23'h000000, dat}, 32'h000001FF);
		check_val(tx_pulses, 1);
		check_val(o_collision_irq, 0);
		// stop bit still shifting, then the shifter runs empty
		bus_rd(uic_pkg::OFS_CTRL, 32'h00000013, 32'h00000077);
		repeat (80) @(posedge clk);
		bus_rd(uic_pkg::OFS_CTRL, 32'h00000033, 32'h00000077);
		// a node jams the line while we send ones
		bus_go(uic_pkg::OFS_TX_DATA, 1'b0, 32'h000001FF);
		wait_for(2, 400);
		repeat (200) @(posedge clk);
		jam <= 1'b1;
		wait_for(1, 300);
		jam <= 1'b0;
		bus_rd(uic_pkg::OFS_CTRL, 32'h00000000, 32'h00000001);
		repeat (30) @(posedge clk);
		check_val(o_serial_out_pin, 1);
		check_val(o_collision_irq, 1);
		bus_go(uic_pkg::OFS_SPECIAL, 1'b0, 32'h0000001A);
		bus_rd(uic_pkg::OFS_SPECIAL, 32'h0000000A, 32'h0000001F);
		check_val(o_collision_irq, 0);
		// timer paced sampling, only timer 3 counts on channel 0
		bus_go(uic_pkg::OFS_SPECIAL, 1'b0, 32'h00000009);
		jam <= 1'b1;
		repeat (300) @(posedge clk);
		check_val(o_collision_irq, 0);
		pulse_timer(5'h10);
		check_val(o_collision_irq, 0);
		pulse_timer(5'h08);
		check_val(o_collision_irq, 1);
		jam <= 1'b0;
		// external clock: 32 clocks a bit; start on input rise; complete irq
		bus_go(uic_pkg::OFS_SPECIAL, 1'b0, 32'h0000001D);
		bus_go(uic_pkg::OFS_MODE, 1'b0, 32'h00000001);
		bus_go(uic_pkg::OFS_CTRL, 1'b0, 32'h00000007);
		dat = (9'($urandom()) & 9'h1F8) | 9'h002;
		bus_go(uic_pkg::OFS_TX_DATA, 1'b0, {23'h000000, dat});
		repeat (100) @(posedge clk);
		check_val(o_serial_out_pin, 1);
		jam <= 1'b1;
		repeat (2) @(posedge clk);
		jam <= 1'b0;
		wait_for(2, 5);
		while (o_serial_out_pin === 1'b0) @(posedge clk);
		n = 0;
		while (o_serial_out_pin === 1'b1) begin
			n++;
			@(posedge clk);
		end
		check_val(n, 32);
		repeat (400) @(posedge clk);
		check_val(tx_pulses, 3);
		// inverted levels, then open drain released at idle
		bus_go(uic_pkg::OFS_MODE, 1'b0, 32'h00000002);
		repeat (3) @(posedge clk);
		check_val({o_serial_out_pin, o_serial_out_oe}, 2'b01);
		bus_go(uic_pkg::OFS_MODE, 1'b0, 32'h00000010);
		repeat (3) @(posedge clk);
		check_val(o_serial_out_oe, 0);
		print_verdict();
	end
endmodule : uart_bus_collision_mode_tb_top
`default_nettype wire
